// ### bench/dpc_core_asserts.sv
// Checker of the converter control outputs against the pin inputs
module dpc_checker
  import dpc_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic reset_n_in,
  input wire logic output_preset_n_in,
  input wire logic load_strobe_n_in,
  input wire logic sync_n_in,
  input wire logic sclk_in,
  input wire logic sdin_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_out,
  input wire logic [17:0] dac_level_out,
  input wire logic [17:0] output_code_out,
  input wire logic converter_hiz_out,
  input wire logic output_ground_clamp_out,
  input wire logic internal_amplifier_en_out,
  input wire logic feedback_series_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  // Pin reset holds code, level, clamp, high-impedance and amplifier outputs at their defaults
  pin_reset_a: assert property (
    (!reset_n_in) [*6] |-> output_code_out == 18'h00000 && dac_level_out == 18'h20000
      && output_ground_clamp_out && converter_hiz_out && !internal_amplifier_en_out)
    else $error("outputs not at defaults while reset pin low");
  pin_clamp_a: assert property (
    $fell(reset_n_in) ##1 (!reset_n_in) [*2] |-> ##[0:3] output_ground_clamp_out)
    else $error("reset pin did not clamp output");
  // Amplifier and resistor network move together
  amp_pair_a: assert property (
    internal_amplifier_en_out == feedback_series_out)
    else $error("amplifier and feedback network disagree");
  clamp_hiz_a: assert property (
    output_ground_clamp_out |-> converter_hiz_out)
    else $error("clamp active with converter driven");
  code_map_a: assert property (
    $stable(output_code_out) |-> (dac_level_out ^ output_code_out) inside {18'h00000, 18'h20000})
    else $error("converter level not mapped from code");
  preset_hold_a: assert property (
    (reset_n_in && !output_preset_n_in && sync_n_in) [*8] |-> $stable(output_code_out))
    else $error("code changed while preset held");
  load_rise_a: assert property (
    (reset_n_in && output_preset_n_in && load_strobe_n_in && sync_n_in) [*8]
      |-> $stable(output_code_out))
    else $error("code changed with strobes idle");
  sdo_idle_a: assert property (
    sync_n_in [*6] |-> !sdo_oe_out)
    else $error("serial output driven outside frame");

  cover property ($fell(output_preset_n_in) && reset_n_in);
  cover property ($fell(load_strobe_n_in) && output_preset_n_in);
  cover property ($rose(sdo_oe_out));
endmodule : dpc_checker

bind dpc_core dpc_checker #(.SYNC_STAGES(SYNC_STAGES)) u_chk (.core_clk_in(core_clk_in),
  .srst_in(srst_in), .reset_n_in(reset_n_in), .output_preset_n_in(output_preset_n_in),
  .load_strobe_n_in(load_strobe_n_in), .sync_n_in(sync_n_in), .sclk_in(sclk_in),
  .sdin_in(sdin_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
  .dac_level_out(dac_level_out), .output_code_out(output_code_out),
  .converter_hiz_out(converter_hiz_out), .output_ground_clamp_out(output_ground_clamp_out),
  .internal_amplifier_en_out(internal_amplifier_en_out),
  .feedback_series_out(feedback_series_out));

// ### bench/dpc_host_model.sv
// Host side model: sends serial frames of up to 24 bits and samples readback data
module dpc_host_model
  import dpc_pkg::*;
(
  input wire logic sdo_in,
  input wire logic sdo_oe_in,
  output logic sync_n_out,
  output logic sclk_out,
  output logic sdin_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [23:0] rd_q;
  logic oe_seen_q;

  // Serial clock stands still high between frames
  initial begin
    sync_n_out = 1'b1;
    sclk_out = 1'b1;
    sdin_out = 1'b0;
    rd_q = 24'h000000;
    oe_seen_q = 1'b0;
  end

  // One frame of nbits, MSB first; 400 ns link clock period
  task automatic send(input logic [23:0] frame, input int nbits);
    #13 sync_n_out = 1'b0;
    oe_seen_q = 1'b1;
    for (int i = 0; i < nbits; i++) begin
      sdin_out = frame[23 - i];
      // Sample at the falling edge, before the device shifts; released line reads inverted
      #200 rd_q = {rd_q[22:0], sdo_oe_in ? sdo_in : ~sdo_in};
      oe_seen_q = oe_seen_q & sdo_oe_in;
      sclk_out = 1'b0;
      #200 sclk_out = 1'b1;
    end
    // Released data line shows no stale bit
    sdin_out = ~sdin_out;
    #200 sync_n_out = 1'b1;
    #400;
  endtask : send
endmodule : dpc_host_model

// ### bench/test_dac_pin_and_register_control.sv
// Self-checking bench of the converter pin and register control
module test_dac_pin_and_register_control
  import dpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rst_n = 1'b1;
  logic preset_n = 1'b1;
  logic load_n = 1'b1;
  logic sync_n, sclk, sdin, sdo, sdo_oe, hiz, clamp, amp_en, series;
  logic [17:0] level, code;
  int err_total = 0;
  int comparisons = 0;

  always #25 clk = ~clk;

  dpc_core dut (.core_clk_in(clk), .srst_in(srst), .reset_n_in(rst_n),
    .output_preset_n_in(preset_n), .load_strobe_n_in(load_n), .sync_n_in(sync_n),
    .sclk_in(sclk), .sdin_in(sdin), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .dac_level_out(level), .output_code_out(code), .converter_hiz_out(hiz),
    .output_ground_clamp_out(clamp), .internal_amplifier_en_out(amp_en),
    .feedback_series_out(series));
  dpc_host_model host (.sdo_in(sdo), .sdo_oe_in(sdo_oe), .sync_n_out(sync_n),
    .sclk_out(sclk), .sdin_out(sdin));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Write frame, then let register and outputs settle
  task automatic wr(input logic [2:0] addr, input logic [19:0] data);
    host.send({1'b0, addr, data}, 24);
    tick(6);
  endtask : wr

  // Read frame, then a no-op frame that shifts the answer out
  task automatic rd(input logic [2:0] addr);
    host.send({1'b1, addr, 20'h00000}, 24);
    host.send(24'h000000, 24);
  endtask : rd

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    chk("code", 24'h0, 24'(code));
    chk("level", 24'h20000, 24'(level));
    chk("clamp", 24'h1, 24'(clamp));
    chk("hiz", 24'h1, 24'(hiz));
    chk("series", 24'h0, 24'(series));
    chk("amp", 24'h0, 24'(amp_en));
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_mode();
    wr(ADDR_MODE, 20'h00010);
    chk("clamp", 24'h0, 24'(clamp));
    chk("hiz", 24'h0, 24'(hiz));
    chk("amp", 24'h1, 24'(amp_en));
    chk("series", 24'h1, 24'(series));
    rd(ADDR_MODE);
    chk("readback", {1'b1, ADDR_MODE, 20'h00010}, host.rd_q);
    chk("sdo on", 24'h1, 24'(host.oe_seen_q));
    // Clamp set with the high-impedance bit set: that bit must not be stored
    wr(ADDR_MODE, 20'h0001c);
    chk("hiz", 24'h1, 24'(hiz));
    rd(ADDR_MODE);
    chk("hiz bit", {1'b1, ADDR_MODE, 20'h00014}, host.rd_q);
    wr(ADDR_MODE, 20'h00030);
    rd(ADDR_MODE);
    chk("sdo off", 24'h0, 24'(host.oe_seen_q));
    wr(ADDR_MODE, 20'h00010);
    $display("test mode done");
  endtask : t_mode

  task automatic t_load();
    wr(ADDR_CODE, {18'h2a5c3, 2'b11});
    chk("code pending", 24'h0, 24'(code));
    @(posedge clk) load_n <= 1'b0;
    tick(6);
    chk("code", 24'h2a5c3, 24'(code));
    chk("level", 24'h2a5c3, 24'(level));
    @(posedge clk) load_n <= 1'b1;
    tick(6);
    chk("code", 24'h2a5c3, 24'(code));
    @(posedge clk) load_n <= 1'b0;
    wr(ADDR_CODE, {18'h15a3c, 2'b00});
    chk("code", 24'h15a3c, 24'(code));
    @(posedge clk) load_n <= 1'b1;
    $display("test load done");
  endtask : t_load

  task automatic t_preset();
    wr(ADDR_PRESET, {18'h3f00f, 2'b00});
    chk("code", 24'h15a3c, 24'(code));
    @(posedge clk) preset_n <= 1'b0;
    tick(6);
    chk("code", 24'h3f00f, 24'(code));
    chk("level", 24'h3f00f, 24'(level));
    wr(ADDR_CODE, {18'h01234, 2'b00});
    @(posedge clk) load_n <= 1'b0;
    tick(6);
    chk("code", 24'h3f00f, 24'(code));
    @(posedge clk) preset_n <= 1'b1;
    tick(6);
    chk("code", 24'h3f00f, 24'(code));
    @(posedge clk) load_n <= 1'b1;
    wr(ADDR_MODE, 20'h00000);
    wr(ADDR_PRESET, {18'h00abc, 2'b00});
    @(posedge clk) preset_n <= 1'b0;
    tick(6);
    chk("level", 24'h20abc, 24'(level));
    @(posedge clk) preset_n <= 1'b1;
    tick(6);
    chk("code", 24'h00abc, 24'(code));
    $display("test preset done");
  endtask : t_preset

  task automatic t_short_frame();
    @(posedge clk) load_n <= 1'b0;
    // First 23 bits would decode as a code write if the count went unchecked
    host.send(24'h3fffff, 23);
    tick(6);
    chk("code", 24'h00abc, 24'(code));
    @(posedge clk) load_n <= 1'b1;
    $display("test short frame done");
  endtask : t_short_frame

  task automatic t_pin_reset();
    @(posedge clk) rst_n <= 1'b0;
    tick(4);
    @(posedge clk) load_n <= 1'b0;
    wr(ADDR_CODE, {18'h11111, 2'b00});
    wr(ADDR_MODE, 20'h00000);
    chk("code", 24'h0, 24'(code));
    chk("clamp", 24'h1, 24'(clamp));
    @(posedge clk) rst_n <= 1'b1;
    tick(6);
    t_defaults();
    wr(ADDR_CODE, {18'h01234, 2'b00});
    @(posedge clk) preset_n <= 1'b0;
    tick(6);
    chk("code", 24'h0, 24'(code));
    @(posedge clk) preset_n <= 1'b1;
    @(posedge clk) load_n <= 1'b1;
    $display("test pin reset done");
  endtask : t_pin_reset

  // Software load, preset and reset strobes with both pins high
  task automatic t_strobe();
    wr(ADDR_CODE, {18'h0abcd, 2'b00});
    wr(ADDR_STROBE, 20'h00001);
    chk("code", 24'h0abcd, 24'(code));
    wr(ADDR_PRESET, {18'h2d2d2, 2'b00});
    wr(ADDR_STROBE, 20'h00002);
    chk("code", 24'h2d2d2, 24'(code));
    wr(ADDR_MODE, 20'h00010);
    wr(ADDR_STROBE, 20'h00004);
    chk("clamp", 24'h1, 24'(clamp));
    chk("code", 24'h0, 24'(code));
    $display("test strobe done");
  endtask : t_strobe

  // Watchdog over the expected run time
  initial begin
    #1000000;
    err_total++;
    $display("ERROR watchdog expected done seen hang");
    conclude();
  end

  // Main sequence
  initial begin
    tick(2);
    srst <= 1'b0;
    tick(4);
    t_defaults();
    t_mode();
    t_load();
    t_preset();
    t_short_frame();
    t_pin_reset();
    t_strobe();
    conclude();
  end
endmodule : test_dac_pin_and_register_control

// ### common/dpc_pkg.sv
// Constants, field layouts and carrier types of the converter pin and register control
// Notes on behaviour
// - While the reset pin is low the device stays in reset and ignores all frames.
// - A rising reset pin edge restores every register to its power-on default.
// - Preset pin held low overwrites the code register with the preset value continuously.
// - A falling preset pin edge copies the preset value into the code register.
// - Preset high and load strobe low or falling: output follows the code register.
// - Output stays at preset while preset is low or rises with load strobe high.
// - Rising load strobe edge with preset high leaves the output unchanged.
// - Preset register supplies the output value for the preset pin or software preset.
// - Preset value uses the same code format as the code register.
// - Preset register is zero after power-on or reset.
// - Buffer select 0 powers the amplifier up and puts feedback resistors in series.
// - Buffer select 1, the default, powers the amplifier down, resistors in parallel.
// - Ground clamp 0 releases the clamp and runs the converter normally.
// - Ground clamp 1, the default, clamps output to ground and floats the converter.
// - Any reset forces ground clamp mode with the converter floating.
// - While ground clamp is 1, writes to the converter high-impedance bit are ignored.
// - Frames are 24 bits MSB first: read flag, 3-bit address, 20 data bits.
// - Code format defaults to 0, twos complement; 1 selects offset binary.
// - Converter high-impedance bit defaults to 1; 0 selects normal operation.
// - Serial-out disable defaults to 0, output enabled; 1 floats the serial output.
package dpc_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int CODE_BITS = 18;
  localparam int DATA_BITS = 20;
  localparam int RW_POS = 23;
  localparam int ADDR_MSB = 22;
  localparam int ADDR_LSB = 20;
  localparam int DATA_MSB = 19;
  localparam int CODE_LSB = 2;

  // Register addresses
  localparam logic [2:0] ADDR_NOP = 3'h0;
  localparam logic [2:0] ADDR_CODE = 3'h1;
  localparam logic [2:0] ADDR_MODE = 3'h2;
  localparam logic [2:0] ADDR_PRESET = 3'h3;
  localparam logic [2:0] ADDR_STROBE = 3'h4;

  // Mode control field positions
  localparam int MODE_BUF_POS = 1;
  localparam int MODE_CLAMP_POS = 2;
  localparam int MODE_HIZ_POS = 3;
  localparam int MODE_FMT_POS = 4;
  localparam int MODE_SDO_POS = 5;

  // Software strobe field positions
  localparam int STROBE_RESET_POS = 2;
  localparam int STROBE_PRESET_POS = 1;
  localparam int STROBE_LOAD_POS = 0;

  // Reset values
  localparam logic BUF_RST = 1'b1;
  localparam logic CLAMP_RST = 1'b1;
  localparam logic HIZ_RST = 1'b1;
  localparam logic FMT_RST = 1'b0;
  localparam logic SDO_DIS_RST = 1'b0;
  localparam logic [17:0] PRESET_RST = 18'h00000;
  localparam logic [17:0] CODE_RST = 18'h00000;
  localparam logic FMT_TWOS = 1'b0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic serial_out_disable;
    logic code_format_select;
    logic converter_hiz;
    logic output_ground_clamp;
    logic feedback_buffer_select;
  } dpc_mode_t;

  typedef struct packed {
    logic reset_n;
    logic output_preset_n;
    logic load_strobe_n;
    logic sync_n;
    logic sclk;
    logic sdin;
  } dpc_pins_t;

  localparam int PIN_COUNT = 6;
  localparam logic [5:0] PINS_IDLE = 6'h3e;

  typedef enum logic {LINK_IDLE, LINK_SHIFT} dpc_link_state_t;

endpackage : dpc_pkg

// ### core/dpc_core.sv
// Control pins, serial frames and registers of the 18-bit converter
module dpc_core
  import dpc_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic reset_n_in,
  input wire logic output_preset_n_in,
  input wire logic load_strobe_n_in,
  input wire logic sync_n_in,
  input wire logic sclk_in,
  input wire logic sdin_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic [17:0] dac_level_out,
  output logic [17:0] output_code_out,
  output logic converter_hiz_out,
  output logic output_ground_clamp_out,
  output logic internal_amplifier_en_out,
  output logic feedback_series_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("dpc_core needs at least two synchroniser stages");
  end

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Code register value to straight binary for the converter
  function automatic logic [17:0] to_straight(input logic [17:0] code, input logic fmt);
    logic [17:0] res;
    res = code;
    if (fmt == FMT_TWOS) begin
      res[17] = ~code[17];
    end
    return res;
  endfunction : to_straight

  // Mode fields to their bit positions in the data field
  function automatic logic [19:0] pack_mode(input dpc_mode_t m);
    logic [19:0] res;
    res = 20'h00000;
    res[MODE_BUF_POS] = m.feedback_buffer_select;
    res[MODE_CLAMP_POS] = m.output_ground_clamp;
    res[MODE_HIZ_POS] = m.converter_hiz;
    res[MODE_FMT_POS] = m.code_format_select;
    res[MODE_SDO_POS] = m.serial_out_disable;
    return res;
  endfunction : pack_mode

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  dpc_pins_t pins_raw;
  dpc_pins_t lvl;
  dpc_pins_t rise;
  dpc_pins_t fall;

  assign pins_raw = {reset_n_in, output_preset_n_in, load_strobe_n_in,
                     sync_n_in, sclk_in, sdin_in};

  // All pins cross into the core clock before use
  dpc_pin_sync #(
    .WIDTH(PIN_COUNT),
    .STAGES(SYNC_STAGES),
    .IDLE(PINS_IDLE)
  ) u_pin_sync (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .raw_in(pins_raw),
    .level_out(lvl),
    .rise_out(rise),
    .fall_out(fall)
  );

  // ----------------------------------------------------------------
  // Reset hold
  // ----------------------------------------------------------------
  logic sw_reset_q;
  logic rst_hold;

  // Reset pin low, its rising edge, software reset or core reset
  assign rst_hold = srst_in | ~lvl.reset_n | rise.reset_n | sw_reset_q;

  // ----------------------------------------------------------------
  // Serial frame receiver
  // ----------------------------------------------------------------
  dpc_link_state_t link_q;
  logic [4:0] bit_cnt_q;
  logic [23:0] shift_q;
  logic frame_ok;
  logic frame_rw;
  logic [2:0] frame_addr;
  logic [19:0] frame_data;
  logic frame_end;

  // Frame framing and bit capture on falling serial clock
  always_ff @(posedge core_clk_in) begin
    if (rst_hold) begin
      link_q <= LINK_IDLE;
      bit_cnt_q <= 5'h00;
      shift_q <= 24'h000000;
    end else begin
      case (link_q)
        LINK_IDLE: begin
          if (fall.sync_n) begin
            link_q <= LINK_SHIFT;
            bit_cnt_q <= 5'h00;
          end
        end
        LINK_SHIFT: begin
          if (rise.sync_n) begin
            link_q <= LINK_IDLE;
          end else if (fall.sclk && bit_cnt_q != 5'(FRAME_BITS + 1)) begin
            shift_q <= {shift_q[22:0], lvl.sdin};
            bit_cnt_q <= bit_cnt_q + 5'h01;
          end
        end
        default: begin
          link_q <= LINK_IDLE;
        end
      endcase
    end
  end

  // Frame end and acceptance of exactly 24 bits
  assign frame_end = (link_q == LINK_SHIFT) & rise.sync_n;
  assign frame_ok = frame_end & (bit_cnt_q == 5'(FRAME_BITS)) & ~rst_hold;
  assign frame_rw = shift_q[RW_POS];
  assign frame_addr = shift_q[ADDR_MSB:ADDR_LSB];
  assign frame_data = shift_q[DATA_MSB:0];

  // Decoded write strobes
  logic wr_code;
  logic wr_mode;
  logic wr_preset;
  logic wr_strobe;

  assign wr_code = frame_ok & ~frame_rw & (frame_addr == ADDR_CODE);
  assign wr_mode = frame_ok & ~frame_rw & (frame_addr == ADDR_MODE);
  assign wr_preset = frame_ok & ~frame_rw & (frame_addr == ADDR_PRESET);
  assign wr_strobe = frame_ok & ~frame_rw & (frame_addr == ADDR_STROBE);

  // ----------------------------------------------------------------
  // Mode control register
  // ----------------------------------------------------------------
  dpc_mode_t mode_q;

  // Field updates; reserved bits are not stored
  always_ff @(posedge core_clk_in) begin
    if (rst_hold) begin
      mode_q.feedback_buffer_select <= BUF_RST;
      mode_q.output_ground_clamp <= CLAMP_RST;
      mode_q.converter_hiz <= HIZ_RST;
      mode_q.code_format_select <= FMT_RST;
      mode_q.serial_out_disable <= SDO_DIS_RST;
    end else if (wr_mode) begin
      mode_q.feedback_buffer_select <= frame_data[MODE_BUF_POS];
      mode_q.output_ground_clamp <= frame_data[MODE_CLAMP_POS];
      mode_q.code_format_select <= frame_data[MODE_FMT_POS];
      mode_q.serial_out_disable <= frame_data[MODE_SDO_POS];
      if (!frame_data[MODE_CLAMP_POS]) begin
        mode_q.converter_hiz <= frame_data[MODE_HIZ_POS];
      end
    end
  end

  // ----------------------------------------------------------------
  // Preset register
  // ----------------------------------------------------------------
  logic [17:0] preset_q;

  // Preset value write
  always_ff @(posedge core_clk_in) begin
    if (rst_hold) begin
      preset_q <= PRESET_RST;
    end else if (wr_preset) begin
      preset_q <= frame_data[DATA_MSB:CODE_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Software strobes
  // ----------------------------------------------------------------
  logic sw_load_q;
  logic sw_preset_q;

  // One-cycle pulses from the strobe register
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sw_reset_q <= 1'b0;
      sw_load_q <= 1'b0;
      sw_preset_q <= 1'b0;
    end else begin
      sw_reset_q <= wr_strobe & frame_data[STROBE_RESET_POS];
      sw_load_q <= wr_strobe & frame_data[STROBE_LOAD_POS];
      sw_preset_q <= wr_strobe & frame_data[STROBE_PRESET_POS];
    end
  end

  // ----------------------------------------------------------------
  // Code update and preset logic
  // ----------------------------------------------------------------
  logic [17:0] input_hold_q;
  logic pending_q;
  logic [17:0] output_code_q;
  logic preset_now;
  logic xfer;

  // Preset pin low, or software preset while load strobe is high
  assign preset_now = ~lvl.output_preset_n
                    | (sw_preset_q & lvl.load_strobe_n);

  // Load strobe low level or software load, blocked while preset pin is low
  assign xfer = pending_q & lvl.output_preset_n
              & (~lvl.load_strobe_n | sw_load_q);

  // Serial value held until the next update
  always_ff @(posedge core_clk_in) begin
    if (rst_hold) begin
      input_hold_q <= CODE_RST;
    end else if (wr_code) begin
      input_hold_q <= frame_data[DATA_MSB:CODE_LSB];
    end
  end

  // Pending update; a new write wins over the clear
  always_ff @(posedge core_clk_in) begin
    if (rst_hold) begin
      pending_q <= 1'b0;
    end else if (wr_code) begin
      pending_q <= 1'b1;
    end else if (xfer || preset_now) begin
      pending_q <= 1'b0;
    end
  end

  // Code register driving the converter
  always_ff @(posedge core_clk_in) begin
    if (rst_hold) begin
      output_code_q <= CODE_RST;
    end else if (preset_now) begin
      output_code_q <= preset_q;
    end else if (xfer) begin
      output_code_q <= input_hold_q;
    end
  end

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  logic [23:0] out_q;
  logic rd_armed_q;
  logic [19:0] rd_data;

  // Data field of the addressed register
  always_comb begin
    rd_data = 20'h00000;
    case (frame_addr)
      ADDR_CODE: rd_data = {output_code_q, 2'b00};
      ADDR_MODE: rd_data = pack_mode(mode_q);
      ADDR_PRESET: rd_data = {preset_q, 2'b00};
      default: rd_data = 20'h00000;
    endcase
  end

  // Load on a read frame, shift on falling serial clock of the next
  always_ff @(posedge core_clk_in) begin
    if (rst_hold) begin
      out_q <= 24'h000000;
      rd_armed_q <= 1'b0;
    end else if (frame_ok && frame_rw && frame_addr != ADDR_NOP) begin
      out_q <= {1'b1, frame_addr, rd_data};
      rd_armed_q <= 1'b1;
    end else if (frame_end) begin
      rd_armed_q <= 1'b0;
    end else if (link_q == LINK_SHIFT && fall.sclk && rd_armed_q) begin
      out_q <= {out_q[22:0], 1'b0};
    end
  end

  // Serial output driven only inside a frame that follows a read
  assign sdo_out = out_q[23];
  assign sdo_oe_out = rd_armed_q & (link_q == LINK_SHIFT)
                    & ~mode_q.serial_out_disable;

  // ----------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------

  // Registered converter code and switch controls
  always_ff @(posedge core_clk_in) begin
    if (rst_hold) begin
      dac_level_out <= to_straight(CODE_RST, FMT_RST);
      output_code_out <= CODE_RST;
      converter_hiz_out <= 1'b1;
      output_ground_clamp_out <= 1'b1;
      internal_amplifier_en_out <= ~BUF_RST;
      feedback_series_out <= ~BUF_RST;
    end else begin
      dac_level_out <= to_straight(output_code_q, mode_q.code_format_select);
      output_code_out <= output_code_q;
      converter_hiz_out <= mode_q.output_ground_clamp
                         | mode_q.converter_hiz;
      output_ground_clamp_out <= mode_q.output_ground_clamp;
      internal_amplifier_en_out <= ~mode_q.feedback_buffer_select;
      feedback_series_out <= ~mode_q.feedback_buffer_select;
    end
  end

endmodule : dpc_core

// ### core/dpc_pin_sync.sv
// Multi-stage pin synchroniser with edge detection
module dpc_pin_sync
  import dpc_pkg::*;
#(
  parameter int WIDTH = PIN_COUNT,
  parameter int STAGES = 2,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (STAGES < 2) begin : g_bad_stages
    $error("dpc_pin_sync needs at least two stages");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("dpc_pin_sync needs a width of at least one");
  end

  logic [WIDTH-1:0] stage_q [STAGES];
  logic [WIDTH-1:0] prev_q;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= IDLE;
      end
    end else begin
      stage_q[0] <= raw_in;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  // Previous settled level for edge finding
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      prev_q <= IDLE;
    end else begin
      prev_q <= stage_q[STAGES-1];
    end
  end

  // Settled level and one-cycle edge pulses
  assign level_out = stage_q[STAGES-1];
  assign rise_out = stage_q[STAGES-1] & ~prev_q;
  assign fall_out = ~stage_q[STAGES-1] & prev_q;

endmodule : dpc_pin_sync
